/* inc/standby_pkg.sv */
/*
 Constants for the standby wake-up command block.
 Assumes a 40 MHz system clock; no bus, plain ports.
*/
package standby_pkg;
   // ---------------------------------------------
   // Configuration byte fields
   // ---------------------------------------------
   localparam int CFG_DEEP_BIT = 7;
   localparam int CFG_RSVD_BIT = 6;
   localparam int CFG_GPIO_HI = 5;
   localparam int CFG_GPIO_LO = 2;
   localparam int CFG_CNT_BIT = 1;
   localparam int CFG_RF_BIT = 0;
   // ---------------------------------------------
   // Counter limits in milliseconds
   // ---------------------------------------------
   localparam logic [15:0] MAX_MS_NORMAL = 16'h0A82;
   localparam logic [15:0] MAX_MS_DEEP = 16'h0FFF;
   // ---------------------------------------------
   // Status and reason codes
   // ---------------------------------------------
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] STATUS_FAIL = 8'h01;
   localparam logic [7:0] REASON_NONE = 8'h00;
   localparam logic [7:0] REASON_DEEP_LOCKED = 8'h01;
   localparam logic [7:0] REASON_BAD_COUNT = 8'h02;
   // Wake source codes in wake event
   localparam logic [7:0] WAKE_GPIO = 8'h01;
   localparam logic [7:0] WAKE_COUNTER = 8'h02;
   localparam logic [7:0] WAKE_RF = 8'h04;
   localparam logic [7:0] WAKE_ABORT = 8'h08;
   // ---------------------------------------------
   // Timing: one millisecond tick
   // ---------------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
endpackage

/* hdl/standby_wakeup_command.sv */
/*
 Standby wake-up command interpreter: takes config and counter bytes,
 answers a status byte, enters standby after the response is read,
 and raises wake or prevented events.
 Assumes the host interface layer presents bytes with a strobe and
 reports when the response has been fully read.
*/
// Summary of operation
// - Config bit 7 picks ultra-low-power standby, bits 5..2 enable GPIO-3..0 high wake in normal standby.
// - Bit 1 enables counter-expiry wake, bit 0 enables RF-field wake, counter always on in ultra-low-power.
// - The counter value is used only when counter wake is enabled, otherwise ignored.
// - Counter expiry always ends ultra-low-power standby and a host abort always ends normal standby.
// - Standby ends as soon as any configured wake source meets its condition.
// - The command answers one status byte, ok or fail when settings are wrong.
// - Standby is entered only after the host has fully read the response.
// - On wake and return to normal mode an event is sent to the host.
// - If standby is prevented a prevented event with a reason code is sent.
// - Ultra-low-power standby is refused when the persistent lowest-power card flag is set.
`timescale 1ns/1ps
module standby_wakeup_command
   import standby_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic cmd_start,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic resp_read_done,
   input wire logic card_emulation_lowest_power_flag,
   input wire logic [3:0] gpio_in,
   input wire logic rf_field,
   input wire logic host_interface_abort,
   output logic resp_valid,
   output logic [7:0] resp_status,
   output logic in_standby,
   output logic ultra_low_power,
   output logic wake_event,
   output logic prevented_event,
   output logic [7:0] event_code,
   output logic busy
);
   // ---------------------------------------------
   // State machine
   // ---------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_CFG = 6'b000010,
      ST_LO = 6'b000100,
      ST_HI = 6'b001000,
      ST_RESP = 6'b010000,
      ST_SLEEP = 6'b100000
   } state_e;

   state_e state;
   logic [7:0] cfg;
   logic [15:0] count_ms;
   logic [15:0] tick_div;
   logic ms_tick;
   logic [15:0] ms_left;
   logic settings_ok;
   logic [7:0] fail_reason;
   logic deep_sel;
   logic cnt_en;
   logic [3:0] gpio_en;
   logic gpio_hit;
   logic cnt_hit;
   logic wake_now;
   logic [7:0] wake_src;

   function automatic logic [15:0] limit_for(input logic deep);
      return deep ? MAX_MS_DEEP : MAX_MS_NORMAL;
   endfunction

   assign deep_sel = cfg[CFG_DEEP_BIT];
   assign cnt_en = cfg[CFG_CNT_BIT] | deep_sel;
   assign gpio_en = deep_sel ? 4'h0 : cfg[CFG_GPIO_HI:CFG_GPIO_LO];

   // Settings check decides status and prevention
   always_comb begin
      settings_ok = 1'b1;
      fail_reason = REASON_NONE;
      if (deep_sel && card_emulation_lowest_power_flag) begin
         settings_ok = 1'b0;
         fail_reason = REASON_DEEP_LOCKED;
      end else if (cnt_en && (count_ms > limit_for(deep_sel))) begin
         settings_ok = 1'b0;
         fail_reason = REASON_BAD_COUNT;
      end
   end

   // ---------------------------------------------
   // Wake detection
   // ---------------------------------------------
   assign gpio_hit = |(gpio_en & gpio_in);
   assign cnt_hit = cnt_en && (ms_left == 16'h0000);
   always_comb begin
      wake_src = 8'h00;
      if (gpio_hit) begin
         wake_src = wake_src | WAKE_GPIO;
      end
      if (cnt_hit) begin
         wake_src = wake_src | WAKE_COUNTER;
      end
      if (cfg[CFG_RF_BIT] && rf_field) begin
         wake_src = wake_src | WAKE_RF;
      end
      if (!deep_sel && host_interface_abort) begin
         wake_src = wake_src | WAKE_ABORT;
      end
   end
   assign wake_now = (state == ST_SLEEP) && (wake_src != 8'h00);

   // ---------------------------------------------
   // Command sequencer
   // ---------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_start) begin
                  state <= ST_CFG;
               end
            end
            ST_CFG: begin
               if (byte_valid) begin
                  state <= ST_LO;
               end
            end
            ST_LO: begin
               if (byte_valid) begin
                  state <= ST_HI;
               end
            end
            ST_HI: begin
               if (byte_valid) begin
                  state <= ST_RESP;
               end
            end
            ST_RESP: begin
               if (resp_read_done) begin
                  state <= settings_ok ? ST_SLEEP : ST_IDLE;
               end
            end
            ST_SLEEP: begin
               if (wake_now) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Parameter capture, counter little endian
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg <= 8'h00;
         count_ms <= 16'h0000;
      end else if (byte_valid) begin
         if (state == ST_CFG) begin
            cfg <= byte_data;
         end else if (state == ST_LO) begin
            count_ms[7:0] <= byte_data;
         end else if (state == ST_HI) begin
            count_ms[15:8] <= byte_data;
         end
      end
   end

   // ---------------------------------------------
   // Millisecond wake-up counter
   // ---------------------------------------------
   assign ms_tick = (tick_div == TICK_LAST);
   always_ff @(posedge sys_clk) begin
      if (sys_rst || state != ST_SLEEP) begin
         tick_div <= 16'h0000;
      end else begin
         tick_div <= ms_tick ? 16'h0000 : tick_div + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ms_left <= 16'hFFFF;
      end else if (state == ST_RESP) begin
         ms_left <= count_ms;
      end else if (state == ST_SLEEP && ms_tick && ms_left != 16'h0000) begin
         ms_left <= ms_left - 16'h0001;
      end
   end

   // ---------------------------------------------
   // Response and events
   // ---------------------------------------------
   assign resp_valid = (state == ST_RESP);
   assign in_standby = (state == ST_SLEEP);
   assign busy = (state != ST_IDLE);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         resp_status <= STATUS_OK;
      end else if (state == ST_HI && byte_valid) begin
         resp_status <= STATUS_OK;
      end else if (state == ST_RESP) begin
         resp_status <= settings_ok ? STATUS_OK : STATUS_FAIL;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ultra_low_power <= 1'b0;
      end else if (state == ST_RESP && resp_read_done && settings_ok) begin
         ultra_low_power <= deep_sel;
      end else if (wake_now) begin
         ultra_low_power <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wake_event <= 1'b0;
         prevented_event <= 1'b0;
         event_code <= 8'h00;
      end else begin
         wake_event <= wake_now;
         prevented_event <= (state == ST_RESP) && resp_read_done && !settings_ok;
         if (wake_now) begin
            event_code <= wake_src;
         end else if (state == ST_RESP && resp_read_done && !settings_ok) begin
            event_code <= fail_reason;
         end
      end
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   sequence read_ok_s;
      state == ST_RESP && resp_read_done && settings_ok;
   endsequence

   sequence refuse_s;
      state == ST_RESP && resp_read_done && !settings_ok;
   endsequence

   no_early_sleep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(in_standby) |-> $past(resp_read_done))
      else $error("standby entered before response read");
   sleep_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      read_ok_s |=> in_standby)
      else $error("standby not entered after read");
   wake_event_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wake_now |=> wake_event && !in_standby)
      else $error("wake event missing");
   prevent_event_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      refuse_s |=> prevented_event && !in_standby)
      else $error("prevented event missing");
   deep_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (resp_valid && deep_sel && card_emulation_lowest_power_flag) |=> resp_status == STATUS_FAIL)
      else $error("locked ultra low power not refused");
   abort_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (in_standby && !deep_sel && host_interface_abort) |=> !in_standby)
      else $error("abort did not end standby");
   gpio_ignore_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (in_standby && deep_sel && !cnt_hit && !(cfg[CFG_RF_BIT] && rf_field)) |=> in_standby)
      else $error("ultra low power woke without source");
   count_limit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (resp_valid && !deep_sel && cfg[CFG_CNT_BIT] && count_ms > MAX_MS_NORMAL && !card_emulation_lowest_power_flag)
      |=> resp_status == STATUS_FAIL)
      else $error("over-limit count accepted");
   status_ok_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (resp_valid && settings_ok) ##1 resp_valid |-> resp_status == STATUS_OK)
      else $error("good settings gave fail status");
   status_fail_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (resp_valid && !settings_ok) ##1 resp_valid |-> resp_status == STATUS_FAIL)
      else $error("bad settings gave ok status");
   resp_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (resp_valid && !resp_read_done) |=> resp_valid)
      else $error("response dropped before read");
   deep_kind_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      read_ok_s |=> ultra_low_power == $past(deep_sel))
      else $error("standby kind not taken from config");
   refuse_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      refuse_s |=> event_code == $past(fail_reason) && !busy)
      else $error("prevented reason code wrong");

   // ---------------------------------------------
   // Wake checks
   // ---------------------------------------------
   event_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wake_event |=> !wake_event)
      else $error("wake event longer than one cycle");
   counter_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (in_standby && cnt_hit) |=> wake_event && (event_code & WAKE_COUNTER) != 8'h00)
      else $error("counter expiry did not wake");
   gpio_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (in_standby && gpio_hit) |=> wake_event && (event_code & WAKE_GPIO) != 8'h00)
      else $error("enabled gpio did not wake");
   rf_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (in_standby && cfg[CFG_RF_BIT] && rf_field) |=> wake_event && (event_code & WAKE_RF) != 8'h00)
      else $error("enabled rf field did not wake");
endmodule

/* bench/standby_host_model.sv */
/*
 Host controller model: sends the standby command and its payload,
 then reads the status byte after a deliberate delay.
 Assumes the block samples all inputs on rising sys_clk edges.
*/
`timescale 1ns/1ps
module standby_host_model (
   input wire logic sys_clk,
   input wire logic resp_valid,
   input wire logic [7:0] resp_status,
   input wire logic in_standby,
   output logic cmd_start,
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic resp_read_done
);
   int early_count = 0;
   int resp_miss = 0;
   initial begin
      cmd_start = 0;
      byte_valid = 0;
      byte_data = 8'hA5;
      resp_read_done = 0;
   end
   // ---------------------------------------------
   // Command, payload and delayed response read
   // ---------------------------------------------
   task automatic run_command(input logic [7:0] cfg, input logic [15:0] cnt, output logic [7:0] status);
      int n;
      n = 0;
      @(posedge sys_clk) #2 cmd_start = 1;
      @(posedge sys_clk) #2 cmd_start = 0;
      byte_valid = 1;
      byte_data = cfg & 8'hBF;
      @(posedge sys_clk) #2 byte_data = cnt[7:0];
      @(posedge sys_clk) #2 byte_data = cnt[15:8];
      @(posedge sys_clk) #2 byte_valid = 0;
      byte_data = ~cnt[15:8];
      while (resp_valid !== 1'b1 && n < 20) begin
         @(posedge sys_clk) #2 n++;
      end
      resp_miss += int'(n != 0);
      // Holding the read back shows any early standby entry
      repeat (3) begin
         @(posedge sys_clk) #2 early_count += int'(in_standby === 1'b1);
         resp_miss += int'(resp_valid !== 1'b1);
      end
      status = resp_status;
      resp_read_done = 1;
      @(posedge sys_clk) #2 resp_read_done = 0;
      resp_miss += int'(resp_valid !== 1'b0);
   endtask
endmodule

/* bench/standby_wakeup_command_tb.sv */
/*
 Self-checking bench for the standby wake-up command block.
 Assumes the host model drives the command side; bench drives wake sources.
*/
`timescale 1ns/1ps
module standby_wakeup_command_tb;
   import standby_pkg::*;
   logic sys_clk = 0, sys_rst = 1, card_emulation_lowest_power_flag = 0, rf_field = 0, host_interface_abort = 0;
   logic [3:0] gpio_in = 0;
   logic cmd_start, byte_valid, resp_read_done, resp_valid, in_standby, ultra_low_power;
   logic wake_event, prevented_event, busy, deep_seen;
   logic [7:0] byte_data, resp_status, event_code, st;
   int err_count = 0, num_checks = 0, cycles = 0;
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   standby_wakeup_command u_standby_wakeup_command (.sys_clk, .sys_rst, .cmd_start, .byte_valid, .byte_data,
      .resp_read_done, .card_emulation_lowest_power_flag, .gpio_in, .rf_field, .host_interface_abort,
      .resp_valid, .resp_status, .in_standby, .ultra_low_power, .wake_event, .prevented_event, .event_code, .busy);
   standby_host_model u_standby_host_model (.sys_clk, .resp_valid, .resp_status, .in_standby, .cmd_start,
      .byte_valid, .byte_data, .resp_read_done);
   // ---------------------------------------------
   // Compare, verdict and timeout
   // ---------------------------------------------
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         give_verdict();
      end
   end
   // ---------------------------------------------
   // Shared steps
   // ---------------------------------------------
   task automatic issue(input logic [7:0] cfg, input logic [15:0] cnt, input logic [7:0] exp);
      u_standby_host_model.run_command(cfg, cnt, st);
      check8(st, exp);
   endtask
   task automatic expect_event(input logic is_wake, input logic [7:0] code, input logic deep);
      int n;
      n = 0;
      deep_seen = 0;
      while (wake_event !== 1'b1 && prevented_event !== 1'b1 && n < 50) begin
         deep_seen |= ultra_low_power === 1'b1;
         @(posedge sys_clk) #2 n++;
      end
      check8({7'h0, wake_event}, {7'h0, is_wake});
      check8(event_code, code);
      check8({6'h0, in_standby, busy}, 8'h00);
      if (is_wake) check8({7'h0, deep_seen}, {7'h0, deep});
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic s_gpio();
      issue(8'h04, 16'hFFFF, STATUS_OK);
      gpio_in = 4'hE;
      repeat (3) @(posedge sys_clk);
      #2 check8({7'h0, in_standby}, 8'h01);
      gpio_in = 4'h1;
      expect_event(1'b1, WAKE_GPIO, 1'b0);
      gpio_in = 4'h0;
   endtask
   task automatic s_abort();
      issue(8'h00, 16'h0000, STATUS_OK);
      check8({7'h0, in_standby}, 8'h01);
      host_interface_abort = 1;
      expect_event(1'b1, WAKE_ABORT, 1'b0);
      host_interface_abort = 0;
   endtask
   task automatic s_rf();
      issue(8'h03, 16'h0A82, STATUS_OK);
      gpio_in = 4'hF;
      repeat (2) @(posedge sys_clk);
      #2 check8({7'h0, in_standby}, 8'h01);
      rf_field = 1;
      expect_event(1'b1, WAKE_RF, 1'b0);
      rf_field = 0;
      gpio_in = 4'h0;
   endtask
   task automatic s_deep();
      gpio_in = 4'hF;
      issue(8'hBC, 16'h0000, STATUS_OK);
      expect_event(1'b1, WAKE_COUNTER, 1'b1);
      issue(8'h81, 16'h0001, STATUS_OK);
      host_interface_abort = 1;
      repeat (4) @(posedge sys_clk);
      #2 check8({7'h0, in_standby}, 8'h01);
      host_interface_abort = 0;
      rf_field = 1;
      expect_event(1'b1, WAKE_RF, 1'b1);
      rf_field = 0;
      gpio_in = 4'h0;
   endtask
   task automatic s_refused();
      issue(8'h02, 16'h0A83, STATUS_FAIL);
      expect_event(1'b0, REASON_BAD_COUNT, 1'b0);
      issue(8'h81, 16'h1000, STATUS_FAIL);
      expect_event(1'b0, REASON_BAD_COUNT, 1'b0);
      card_emulation_lowest_power_flag = 1;
      issue(8'h80, 16'h0000, STATUS_FAIL);
      expect_event(1'b0, REASON_DEEP_LOCKED, 1'b0);
      card_emulation_lowest_power_flag = 0;
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      #2 sys_rst = 0;
      check8({resp_valid, in_standby, ultra_low_power, wake_event, prevented_event, busy, 2'b00}, 8'h00);
      s_gpio();
      s_abort();
      s_rf();
      s_deep();
      s_refused();
      check8(8'(u_standby_host_model.early_count), 8'h00);
      check8(8'(u_standby_host_model.resp_miss), 8'h00);
      give_verdict();
   end
endmodule
